// [hdl/pcs_pwm_supply_regs.sv]
// pwm configuration and supply-fault status registers behind a 16-bit spi
`timescale 1ns/1ps

// Overview of operation
// - channel two duty byte; 0 off, 255 on, else duty/255 on-time
// - bit 0 and bit 2 pick 200 Hz (clear) or 400 Hz (set)
// - restart keeps both frequency bits, other frequency bits forced to zero
// - reserved bits read zero and ignore writes
// - scratch byte is host read/write, cleared only at power-up
// - scratch survives soft reset, fail-safe entry and restart
// - scratch reachable only in the active operating mode
// - frame is 16 bits: 7-bit address, mode bit, then data byte
// - data bits 0 to 7 sit in frame bits 8 to 15
// - status read with mode bit zero returns contents unchanged
// - status frame with mode bit one clears the addressed byte
// - read-only bits ignore clears; read/clear bits are cleared
// - flags stay set until host clears; watchdog count lives elsewhere
// - main supply undervoltage sets status bit 6
// - core rail overvoltage sets status bit 1
// - core rail undervoltage prewarning sets status bit 0
// - status zero on power-on and soft reset; restart keeps bits 6,1,0
// - switch configured for the channel two code follows its waveform
module pcs_pwm_supply_regs
  import pcs_pkg::*;
#(
  parameter int PWM_SLOW_PERIOD_CYC_P = PWM_SLOW_PERIOD_CYC,
  parameter int PWM_FAST_PERIOD_CYC_P = PWM_FAST_PERIOD_CYC
)
(
  // clock and reset
  input  wire logic       REF_CLK_I,
  input  wire logic       NRST_I,
  // spi pins
  input  wire logic       SPI_SCK_I,
  input  wire logic       SPI_CS_N_I,
  input  wire logic       SPI_SDI_I,
  output logic            SPI_SDO_O,
  output logic            SPI_SDO_OE_O,
  // device mode and reset events
  input  wire logic       ACTIVE_OPERATING_MODE_I,
  input  wire logic       SOFT_RESET_I,
  input  wire logic       RESTART_I,
  // supply monitor comparators
  input  wire logic       MAIN_SUPPLY_LOW_I,
  input  wire logic       CORE_RAIL_HIGH_I,
  input  wire logic       CORE_RAIL_PREWARN_I,
  // pwm and switch
  input  wire logic [7:0] CHAN1_DUTY_VALUE_I,
  input  wire logic [2:0] HIGH_SIDE_SWITCH_CFG_I,
  output logic            CHAN1_PWM_O,
  output logic            CHAN2_PWM_O,
  output logic            HIGH_SIDE_SWITCH_O,
  // register views
  output logic [7:0]      SUPPLY_FAULT_STATUS_O,
  output logic [7:0]      HOST_SCRATCH_VALUE_O
);

  // step lengths derived from the period counts, never below one cycle
  localparam int SLOW_STEP =
    (PWM_SLOW_PERIOD_CYC_P / 255 < 1) ? 1 : PWM_SLOW_PERIOD_CYC_P / 255;
  localparam int FAST_STEP =
    (PWM_FAST_PERIOD_CYC_P / 255 < 1) ? 1 : PWM_FAST_PERIOD_CYC_P / 255;

  logic       addr_valid, mode, frame_valid;
  logic [6:0] addr;
  logic [7:0] wdata, rdata;
  logic [2:0] flt_raw, f1, f2, f3, flt;
  logic [2:0] next_flt;
  logic [7:0] chan2_duty_value, next_chan2_duty_value;
  logic [7:0] freq_sel, next_freq_sel;
  logic [7:0] host_scratch_value, next_host_scratch_value;
  logic [7:0] status, next_status;
  logic [7:0] set_mask, clr_mask;
  logic       wr_en, clr_en;
  logic [1:0] pwm;
  logic       next_switch;

  // ****************************************************************
  // address decoding helpers
  // ****************************************************************
  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    hit = (a == r);
  endfunction

  // read value of an address; scratch hidden outside the active mode
  function automatic logic [7:0] read_mux(
    input logic [6:0] a,
    input logic       act,
    input logic [7:0] d,
    input logic [7:0] f,
    input logic [7:0] s,
    input logic [7:0] st);
    read_mux = 8'h00;                                // unmapped reads zero
    if (hit(a, ADDR_CHAN2_DUTY))
      read_mux = d;
    else if (hit(a, ADDR_FREQ_SELECT))
      read_mux = f & FREQ_MASK;
    else if (hit(a, ADDR_HOST_SCRATCH) && act)
      read_mux = s;
    else if (hit(a, ADDR_SUPPLY_STATB))
      read_mux = st & STAT_MASK;
  endfunction

  // ****************************************************************
  // spi frame interface
  // ****************************************************************
  pcs_spi_frame pcs_spi_frame_inst (
    .clk_i         (REF_CLK_I),
    .nrst_i        (NRST_I),
    .sck_i         (SPI_SCK_I),
    .cs_n_i        (SPI_CS_N_I),
    .sdi_i         (SPI_SDI_I),
    .sdo_o         (SPI_SDO_O),
    .sdo_oe_o      (SPI_SDO_OE_O),
    .addr_valid_o  (addr_valid),
    .addr_o        (addr),
    .mode_o        (mode),
    .data_o        (wdata),
    .frame_valid_o (frame_valid),
    .rdata_i       (rdata)
  );

  // read data sampled by the frame block after the address byte
  assign rdata = read_mux(addr, ACTIVE_OPERATING_MODE_I, chan2_duty_value,
                          freq_sel, host_scratch_value, status);

  // ****************************************************************
  // fault comparator synchronisers
  // ****************************************************************
  assign flt_raw = {MAIN_SUPPLY_LOW_I, CORE_RAIL_HIGH_I, CORE_RAIL_PREWARN_I};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_flt
      assign next_flt[g] = (f2[g] == f3[g]) ? f3[g] : flt[g];
    end
  endgenerate

  always_ff @(posedge REF_CLK_I)
  begin
    if (!NRST_I)
    begin
      f1  <= 3'h0;
      f2  <= 3'h0;
      f3  <= 3'h0;
      flt <= 3'h0;
    end
    else
    begin
      f1  <= flt_raw;
      f2  <= f1;
      f3  <= f2;
      flt <= next_flt;
    end
  end

  // ****************************************************************
  // register next values
  // ****************************************************************
  assign wr_en  = frame_valid & mode;
  assign clr_en = wr_en & hit(addr, ADDR_SUPPLY_STATB);

  // event bits that hardware sets
  always_comb
  begin
    set_mask                   = 8'h00;
    set_mask[MAIN_LOW_BIT]     = flt[2];
    set_mask[CORE_HIGH_BIT]    = flt[1];
    set_mask[CORE_PREWARN_BIT] = flt[0];
    clr_mask                   = clr_en ? STAT_MASK : 8'h00;
  end

  always_comb
  begin
    next_chan2_duty_value   = chan2_duty_value;
    next_freq_sel           = freq_sel;
    next_host_scratch_value = host_scratch_value;
    // sticky flags, a set in the clearing cycle wins
    next_status = ((status & ~clr_mask) | set_mask) & STAT_MASK;
    if (wr_en && hit(addr, ADDR_CHAN2_DUTY))
      next_chan2_duty_value = wdata;
    if (wr_en && hit(addr, ADDR_FREQ_SELECT))
      next_freq_sel = wdata & FREQ_MASK;
    if (wr_en && hit(addr, ADDR_HOST_SCRATCH) && ACTIVE_OPERATING_MODE_I)
      next_host_scratch_value = wdata;
    if (SOFT_RESET_I)
    begin
      next_chan2_duty_value = DUTY_RESET;
      next_freq_sel         = FREQ_RESET;
      next_status           = STAT_RESET;
    end
    else if (RESTART_I)
    begin
      next_freq_sel = freq_sel & FREQ_MASK;
      next_status   = next_status & STAT_MASK;
    end
  end

  // scratch only sees the power-up reset
  always_ff @(posedge REF_CLK_I)
  begin
    if (!NRST_I)
    begin
      chan2_duty_value   <= DUTY_RESET;
      freq_sel           <= FREQ_RESET;
      host_scratch_value <= SCRATCH_RESET;
      status             <= STAT_RESET;
    end
    else
    begin
      chan2_duty_value   <= next_chan2_duty_value;
      freq_sel           <= next_freq_sel;
      host_scratch_value <= next_host_scratch_value;
      status             <= next_status;
    end
  end

  assign SUPPLY_FAULT_STATUS_O = status;
  assign HOST_SCRATCH_VALUE_O  = host_scratch_value;

  // ****************************************************************
  // pwm generators, one per channel
  // ****************************************************************
  generate
    for (g = 0; g < 2; g++)
    begin : g_pwm
      pcs_pwm_gen #(
        .SLOW_STEP_CYC (SLOW_STEP),
        .FAST_STEP_CYC (FAST_STEP)
      ) pcs_pwm_gen_inst (
        .clk_i  (REF_CLK_I),
        .nrst_i (NRST_I),
        .duty_i ((g == 0) ? CHAN1_DUTY_VALUE_I : chan2_duty_value),
        .fast_i ((g == 0) ? freq_sel[CHAN1_SEL_BIT]
                          : freq_sel[CHAN2_SEL_BIT]),
        .pwm_o  (pwm[g])
      );
    end
  endgenerate

  assign CHAN1_PWM_O = pwm[0];
  assign CHAN2_PWM_O = pwm[1];

  // ****************************************************************
  // high-side switch source selection
  // ****************************************************************
  always_comb
  begin
    case (HIGH_SIDE_SWITCH_CFG_I)
      SWITCH_CODE_ON:   next_switch = 1'b1;
      SWITCH_CODE_PWM1: next_switch = pwm[0];
      SWITCH_CODE_PWM2: next_switch = pwm[1];
      default:          next_switch = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!NRST_I)
      HIGH_SIDE_SWITCH_O <= 1'b0;
    else
      HIGH_SIDE_SWITCH_O <= next_switch;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  property p_duty_write;
    wr_en && hit(addr, ADDR_CHAN2_DUTY) && !SOFT_RESET_I
      |=> chan2_duty_value == $past(wdata);
  endproperty
  a_duty_write: assert property (p_duty_write)
    else $error("duty write not stored");

  property p_freq_reserved;
    (freq_sel & ~FREQ_MASK) == 8'h00;
  endproperty
  a_freq_reserved: assert property (p_freq_reserved)
    else $error("reserved frequency bit set");

  property p_restart_freq;
    RESTART_I && !SOFT_RESET_I && !wr_en |=> $stable(freq_sel);
  endproperty
  a_restart_freq: assert property (p_restart_freq)
    else $error("restart changed frequency bits");

  property p_scratch_keep;
    (SOFT_RESET_I || RESTART_I) && !wr_en |=> $stable(host_scratch_value);
  endproperty
  a_scratch_keep: assert property (p_scratch_keep)
    else $error("scratch lost on soft reset or restart");

  property p_scratch_mode;
    wr_en && hit(addr, ADDR_HOST_SCRATCH) && !ACTIVE_OPERATING_MODE_I
      |=> $stable(host_scratch_value);
  endproperty
  a_scratch_mode: assert property (p_scratch_mode)
    else $error("scratch written outside active mode");

  property p_read_keeps;
    frame_valid && !mode && flt == 3'h0 && !SOFT_RESET_I
      |=> $stable(status);
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("status read changed contents");

  property p_clear;
    clr_en && flt == 3'h0 && !SOFT_RESET_I |=> status == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("status clear left bits set");

  property p_sticky;
    status[MAIN_LOW_BIT] && !clr_en && !SOFT_RESET_I
      |=> status[MAIN_LOW_BIT];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without clear");

  property p_main_low;
    flt[2] && !SOFT_RESET_I |=> status[MAIN_LOW_BIT];
  endproperty
  a_main_low: assert property (p_main_low)
    else $error("main supply low not flagged");

  property p_core_high;
    flt[1] && !SOFT_RESET_I |=> status[CORE_HIGH_BIT];
  endproperty
  a_core_high: assert property (p_core_high)
    else $error("core rail high not flagged");

  property p_prewarn;
    flt[0] && !SOFT_RESET_I |=> status[CORE_PREWARN_BIT];
  endproperty
  a_prewarn: assert property (p_prewarn)
    else $error("core rail prewarning not flagged");

  // soft reset beats a fault set in the same cycle
  property p_soft_status;
    SOFT_RESET_I |=> status == STAT_RESET;
  endproperty
  a_soft_status: assert property (p_soft_status)
    else $error("soft reset did not zero status");

  property p_switch_follow;
    HIGH_SIDE_SWITCH_CFG_I == SWITCH_CODE_PWM2 |=> HIGH_SIDE_SWITCH_O
      == $past(pwm[1]);
  endproperty
  a_switch_follow: assert property (p_switch_follow)
    else $error("switch not following channel two");

  c_duty_write: cover property (wr_en && hit(addr, ADDR_CHAN2_DUTY));
  c_status_clr: cover property (clr_en && status != 8'h00);
  c_scratch_wr: cover property (wr_en && hit(addr, ADDR_HOST_SCRATCH)
                                && ACTIVE_OPERATING_MODE_I);
  c_restart:    cover property (RESTART_I && freq_sel != 8'h00);

endmodule

// [shared/pcs_pkg.sv]
// shared constants and types for the pwm and supply-status register slice
package pcs_pkg;

  // ****************************************************************
  // register addresses (7-bit frame address)
  // ****************************************************************
  localparam logic [6:0] ADDR_CHAN2_DUTY   = 7'h19;
  localparam logic [6:0] ADDR_FREQ_SELECT  = 7'h1C;
  localparam logic [6:0] ADDR_HOST_SCRATCH = 7'h1E;
  localparam logic [6:0] ADDR_SUPPLY_STATB = 7'h40;

  // ****************************************************************
  // field positions, masks and reset values
  // ****************************************************************
  localparam int         CHAN1_SEL_BIT     = 0;
  localparam int         CHAN2_SEL_BIT     = 2;
  localparam int         MAIN_LOW_BIT      = 6;
  localparam int         CORE_HIGH_BIT     = 1;
  localparam int         CORE_PREWARN_BIT  = 0;
  localparam logic [7:0] FREQ_MASK         = 8'h05;
  localparam logic [7:0] STAT_MASK         = 8'h43;
  localparam logic [7:0] DUTY_RESET        = 8'h00;
  localparam logic [7:0] FREQ_RESET        = 8'h00;
  localparam logic [7:0] SCRATCH_RESET     = 8'h00;
  localparam logic [7:0] STAT_RESET        = 8'h00;

  // ****************************************************************
  // spi frame layout
  // ****************************************************************
  localparam logic [4:0] FRAME_BITS        = 5'h10;
  localparam logic [4:0] ADDR_BYTE_BITS    = 5'h08;
  localparam logic [2:0] PIN_RESET         = 3'h4;  // cs_n high, others low

  // ****************************************************************
  // high-side switch source codes
  // ****************************************************************
  localparam logic [2:0] SWITCH_CODE_ON    = 3'h1;
  localparam logic [2:0] SWITCH_CODE_PWM1  = 3'h4;
  localparam logic [2:0] SWITCH_CODE_PWM2  = 3'h5;

  // ****************************************************************
  // pwm timing
  // ****************************************************************
  localparam int         CLK_FREQ_HZ       = 25_000_000;
  localparam int         PWM_SLOW_FREQ_HZ  = 200;
  localparam int         PWM_FAST_FREQ_HZ  = 400;
  localparam logic [7:0] PWM_STEPS         = 8'hFF;
  localparam int         PWM_SLOW_PERIOD_CYC = CLK_FREQ_HZ / PWM_SLOW_FREQ_HZ;
  localparam int         PWM_FAST_PERIOD_CYC = CLK_FREQ_HZ / PWM_FAST_FREQ_HZ;

  // spi frame receiver states
  typedef enum logic [1:0]
  {
    SPI_IDLE  = 2'b00,
    SPI_SHIFT = 2'b01,
    SPI_DONE  = 2'b11
  } pcs_spi_state_e;

endpackage

// [hdl/pcs_pwm_gen.sv]
// one pwm channel: step divider, period counter and duty compare
`timescale 1ns/1ps
module pcs_pwm_gen
  import pcs_pkg::*;
#(
  parameter int SLOW_STEP_CYC = 490,
  parameter int FAST_STEP_CYC = 245
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // settings
  input  wire logic [7:0] duty_i,
  input  wire logic       fast_i,
  // waveform
  output logic            pwm_o
);

  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic [7:0]  step_cnt;
  logic [7:0]  next_step_cnt;
  logic [7:0]  duty_q;
  logic [7:0]  next_duty_q;
  logic        fast_q;
  logic        next_fast_q;
  logic        next_pwm;

  // ****************************************************************
  // divider, period counter, latch at period boundary
  // ****************************************************************
  always_comb
  begin
    next_div_cnt  = div_cnt - 16'h0001;
    next_step_cnt = step_cnt;
    next_duty_q   = duty_q;
    next_fast_q   = fast_q;
    if (div_cnt == 16'h0000)
    begin
      next_div_cnt = fast_q ? 16'(FAST_STEP_CYC - 1)
                            : 16'(SLOW_STEP_CYC - 1);
      if (step_cnt == PWM_STEPS - 8'h01)
      begin
        next_step_cnt = 8'h00;
        next_duty_q   = duty_i;
        next_fast_q   = fast_i;
      end
      else
      begin
        next_step_cnt = step_cnt + 8'h01;
      end
    end
    // zero never on, all ones always on, else duty/255
    next_pwm = (step_cnt < duty_q);
  end

  // state registers
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      div_cnt  <= 16'h0000;
      step_cnt <= 8'h00;
      duty_q   <= DUTY_RESET;
      fast_q   <= 1'b0;
      pwm_o    <= 1'b0;
    end
    else
    begin
      div_cnt  <= next_div_cnt;
      step_cnt <= next_step_cnt;
      duty_q   <= next_duty_q;
      fast_q   <= next_fast_q;
      pwm_o    <= next_pwm;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_step_range;
    @(posedge clk_i) disable iff (!nrst_i)
    step_cnt < PWM_STEPS;
  endproperty
  a_step_range: assert property (p_step_range)
    else $error("pwm step counter left its range");

  property p_full_duty_on;
    @(posedge clk_i) disable iff (!nrst_i)
    (duty_q == PWM_STEPS) [*2] |-> pwm_o;
  endproperty
  a_full_duty_on: assert property (p_full_duty_on)
    else $error("full duty did not hold output on");

endmodule

// [hdl/pcs_spi_frame.sv]
// spi slave framing: pin synchronisers, 16-bit frame shift, read data out
`timescale 1ns/1ps
module pcs_spi_frame
  import pcs_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // spi pins
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       sdi_i,
  output logic            sdo_o,
  output logic            sdo_oe_o,
  // frame side
  output logic            addr_valid_o,
  output logic [6:0]      addr_o,
  output logic            mode_o,
  output logic [7:0]      data_o,
  output logic            frame_valid_o,
  input  wire logic [7:0] rdata_i
);

  logic [2:0]     pin_raw;
  logic [2:0]     s1, s2, s3, stable, stable_d;
  logic [2:0]     next_stable;
  pcs_spi_state_e state, next_state;
  logic [4:0]     cnt, next_cnt;
  logic [15:0]    rx, next_rx;
  logic [7:0]     tx, next_tx;
  logic           next_sdo, next_addr_valid, sck_rise, sck_fall;

  assign pin_raw = {cs_n_i, sck_i, sdi_i};

  // ****************************************************************
  // three-stage synchronisers, a change counts once stages 2 and 3 agree
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      assign next_stable[g] = (s2[g] == s3[g]) ? s3[g] : stable[g];
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      s1       <= PIN_RESET;
      s2       <= PIN_RESET;
      s3       <= PIN_RESET;
      stable   <= PIN_RESET;
      stable_d <= PIN_RESET;
    end
    else
    begin
      s1       <= pin_raw;
      s2       <= s1;
      s3       <= s2;
      stable   <= next_stable;
      stable_d <= stable;
    end
  end

  // ****************************************************************
  // frame receiver: sample on sck rise, shift out on sck fall
  // ****************************************************************
  assign sck_rise = stable[1] & ~stable_d[1];
  assign sck_fall = ~stable[1] & stable_d[1];

  always_comb
  begin
    next_state      = state;
    next_cnt        = cnt;
    next_rx         = rx;
    next_tx         = tx;
    next_sdo        = sdo_o;
    next_addr_valid = 1'b0;
    case (state)
      SPI_IDLE:
      begin
        next_cnt = 5'h00;
        next_sdo = 1'b0;
        if (!stable[2])
          next_state = SPI_SHIFT;
      end
      SPI_SHIFT:
      begin
        if (stable[2])
          next_state = SPI_DONE;
        else if (sck_rise && cnt <= FRAME_BITS)
        begin
          next_rx  = {stable[0], rx[15:1]};  // first bit lands in bit 0
          next_cnt = cnt + 5'h01;
          next_addr_valid = (cnt == ADDR_BYTE_BITS - 5'h01);
        end
        else if (sck_fall && cnt >= ADDR_BYTE_BITS && cnt < FRAME_BITS)
          next_sdo = tx[3'(cnt - ADDR_BYTE_BITS)];
        if (addr_valid_o)
          next_tx = rdata_i;
      end
      SPI_DONE:
        next_state = SPI_IDLE;
      default:
        next_state = SPI_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state        <= SPI_IDLE;
      cnt          <= 5'h00;
      rx           <= 16'h0000;
      tx           <= 8'h00;
      sdo_o        <= 1'b0;
      addr_valid_o <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      cnt          <= next_cnt;
      rx           <= next_rx;
      tx           <= next_tx;
      sdo_o        <= next_sdo;
      addr_valid_o <= next_addr_valid;
    end
  end

  // frame fields: address byte then data byte
  // address is in the upper byte after eight bits, in the lower at the end
  assign addr_o        = (cnt == FRAME_BITS) ? rx[6:0] : rx[14:8];
  assign mode_o        = rx[7];
  assign data_o        = rx[15:8];
  assign frame_valid_o = (state == SPI_DONE) && (cnt == FRAME_BITS);
  assign sdo_oe_o      = ~stable[2];

  property p_frame_len;
    @(posedge clk_i) disable iff (!nrst_i)
    frame_valid_o |-> $past(state) == SPI_SHIFT && cnt == FRAME_BITS;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame accepted without sixteen bits");

endmodule

// [verif/pcs_host.sv]
// spi host model: 16-bit frames, lsb first, sck idle low
`timescale 1ns/1ps
module pcs_host
(
  // clock
  input  wire logic clk_i,
  // spi pins
  input  wire logic sdo_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  // frame result
  output logic      done_o,
  output logic [7:0] rdata_o
);
  initial {sck_o, cs_n_o, sdi_o, done_o, rdata_o} = 12'h400;

  // one frame, sck low twenty clocks and high ten per bit, read byte taken on rises 9..16
  task automatic xfer(input logic [15:0] w);
    @(negedge clk_i) cs_n_o = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      repeat (10) @(negedge clk_i);
      sdi_o = w[i];
      repeat (10) @(negedge clk_i);
      sck_o = 1'b1;
      if (i > 7)
        rdata_o[i-8] = sdo_i;
      repeat (10) @(negedge clk_i);
      sck_o = 1'b0;
    end
    repeat (10) @(negedge clk_i);
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o; // no stale level after release
    done_o = 1'b1;
    @(negedge clk_i) done_o = 1'b0;
    repeat (12) @(negedge clk_i); // commit plus idle gap
  endtask
endmodule

// [verif/testbench.sv]
// self-checking bench for the pwm and supply-status register slice
`timescale 1ns/1ps
module testbench;
  import pcs_pkg::*;
  logic       clk = 1'b0, nrst = 1'b0, mode = 1'b1, srst = 1'b0, rst = 1'b0;
  logic       sck, cs_n, sdi, sdo, done, p1, p2, hso, oe;
  logic [2:0] flt = 3'h0, swc = SWITCH_CODE_PWM2;
  logic [7:0] rd, d, s, st, sv, c1 = 8'h00, exp_q[$];
  logic [31:0] lf = 32'h0000_ad49;
  logic [6:0] ad [4] = '{ADDR_CHAN2_DUTY, ADDR_FREQ_SELECT,
                         ADDR_HOST_SCRATCH, ADDR_SUPPLY_STATB};
  logic [7:0] fb [3] = '{8'h01, 8'h02, 8'h40};
  int         mismatches = 0, samples_checked = 0, cyc = 0, n1, n2, n3;

  always #20 clk = ~clk;

  pcs_host pcs_host_inst (.clk_i(clk), .sdo_i(sdo), .sck_o(sck),
    .cs_n_o(cs_n), .sdi_o(sdi), .done_o(done), .rdata_o(rd));

  pcs_pwm_supply_regs #(.PWM_SLOW_PERIOD_CYC_P(2550),
    .PWM_FAST_PERIOD_CYC_P(1275)) pcs_pwm_supply_regs_inst (
    .REF_CLK_I(clk), .NRST_I(nrst), .SPI_SCK_I(sck), .SPI_CS_N_I(cs_n),
    .SPI_SDI_I(sdi), .SPI_SDO_O(sdo), .SPI_SDO_OE_O(oe),
    .ACTIVE_OPERATING_MODE_I(mode), .SOFT_RESET_I(srst), .RESTART_I(rst),
    .MAIN_SUPPLY_LOW_I(flt[2]), .CORE_RAIL_HIGH_I(flt[1]),
    .CORE_RAIL_PREWARN_I(flt[0]), .CHAN1_DUTY_VALUE_I(c1),
    .HIGH_SIDE_SWITCH_CFG_I(swc), .CHAN1_PWM_O(p1), .CHAN2_PWM_O(p2),
    .HIGH_SIDE_SWITCH_O(hso), .SUPPLY_FAULT_STATUS_O(st),
    .HOST_SCRATCH_VALUE_O(sv));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // note the expected read byte, then run the frame
  task automatic fr(input logic [6:0] a, input logic m, input logic [7:0] w,
                    input logic [7:0] e);
    exp_q.push_back(e);
    pcs_host_inst.xfer({w, m, a});
  endtask

  // read all four registers, e packs status, scratch, freq, duty
  task automatic rd4(input logic [31:0] e);
    for (int i = 0; i < 4; i++)
      fr(ad[i], 1'b0, 8'h00, e[8*i+:8]);
  endtask

  // wait a whole slow period so settings latch, then count on cycles over p
  task automatic cnt(input int p);
    repeat (2550) @(negedge clk);
    n1 = 0;
    n2 = 0;
    n3 = 0;
    repeat (p)
    begin
      @(negedge clk);
      n1 += int'(p2);
      n2 += int'(hso);
      n3 += int'(p1);
    end
  endtask

  // result watcher: oldest note against each finished frame
  always @(posedge done)
  begin
    chk("spi read", {8'h00, exp_q.pop_front()}, {8'h00, rd});
    chk("sdo enable", 16'h0001, {15'h0000, oe});
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      mismatches++;
      final_report;
    end
  end

  initial
  begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    rd4(32'h0000_0000);
    lf = lfsr(lfsr(lf));
    d = lf[7:0];
    s = lf[15:8];
    fr(ADDR_CHAN2_DUTY, 1'b1, d, 8'h00);
    fr(ADDR_FREQ_SELECT, 1'b1, 8'hFF, 8'h00);
    fr(ADDR_HOST_SCRATCH, 1'b1, s, 8'h00);
    fr(7'h7F, 1'b1, 8'hFF, 8'h00);
    fr(7'h7F, 1'b0, 8'h00, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      @(negedge clk) flt = 3'h1 << i;
      repeat (8) @(negedge clk);
      flt = 3'h0;
      fr(ADDR_SUPPLY_STATB, 1'b0, 8'h00, fb[i]);
      fr(ADDR_SUPPLY_STATB, 1'b1, 8'hFF, fb[i]);
    end
    flt = 3'h7;
    repeat (8) @(negedge clk);
    flt = 3'h0;
    rst = 1'b1;
    @(negedge clk) rst = 1'b0;
    rd4({STAT_MASK, s, FREQ_MASK, d});
    fr(ADDR_SUPPLY_STATB, 1'b0, 8'h00, STAT_MASK);
    chk("status", 16'h0043, {8'h00, st});
    srst = 1'b1;
    @(negedge clk) srst = 1'b0;
    rd4({8'h00, s, 8'h00, 8'h00});
    mode = 1'b0;
    fr(ADDR_HOST_SCRATCH, 1'b1, ~s, 8'h00);
    mode = 1'b1;
    fr(ADDR_HOST_SCRATCH, 1'b1, 8'h80, s);
    c1 = 8'h40;
    fr(ADDR_CHAN2_DUTY, 1'b1, 8'h80, 8'h00);
    chk("scratch", 16'h0080, {8'h00, sv});
    cnt(2550);
    chk("pwm2 on", 16'h0500, n1[15:0]);
    chk("switch on", 16'h0500, n2[15:0]);
    chk("pwm1 on", 16'h0280, n3[15:0]);
    fr(ADDR_FREQ_SELECT, 1'b1, 8'h05, 8'h00);
    swc = SWITCH_CODE_PWM1;
    cnt(1275);
    chk("pwm2 fast", 16'h0280, n1[15:0]);
    chk("pwm1 fast", 16'h0140, n3[15:0]);
    chk("switch pwm1", 16'h0140, n2[15:0]);
    fr(ADDR_CHAN2_DUTY, 1'b1, 8'hFF, 8'h80);
    swc = SWITCH_CODE_ON;
    cnt(1275);
    chk("pwm2 full", 16'h04FB, n1[15:0]);
    chk("switch on code", 16'h04FB, n2[15:0]);
    chk("sdo idle", 16'h0000, {15'h0000, oe});
    final_report;
  end
endmodule
